// *** src/vdn_pkg.sv ***
//------------------------------------------------------------------------------
// Purpose : Shared constants and types for the video denoise stream shell
// Assumes : One clock, synchronous clock enable, active-low synchronous reset
// Notes   : Pixels travel with their frame and line markers as one struct
//------------------------------------------------------------------------------
// Functional notes
// - Output one line plus 26 cycles late
// - One output pixel per accepted input
// - No input: output valid stops after draining
// - Sink stalled: input ready drops near full
// - Free flow: one pixel per cycle
// - Ready low 26 cycles after each line
// - Ready low one line after each frame
// - Inputs sampled on edge, outputs after
// - Enable low freezes state and outputs
// - Enable low ignores all but reset
// - Reset low acts next edge, enable ignored
// - Irq only when HAS_CTRL configured; no control port
// - Nine-bit external irq vector when configured
// - Stream ports follow video stream protocol
// - Beat moves on ready, valid, enable, reset
// - Start-of-frame marks first pixel only
// - End-of-line marks last pixel only
package vdn_pkg;

  //----------------------------------------------------------------------------
  // Constants
  //----------------------------------------------------------------------------
  localparam int VDN_FLUSH_CYCLES = 26;                   // Line-end pipeline flush
  localparam int VDN_PIPE_STAGES  = VDN_FLUSH_CYCLES - 1; // Registers behind line buffer
  localparam int VDN_PIX_W        = 24;                   // Packed YCbCr word width
  localparam int VDN_COLS         = 1920;                 // Default active pixels per line
  localparam int VDN_ROWS         = 1080;                 // Default active lines per frame
  localparam int VDN_FIFO_DEPTH   = 16;                   // Input buffer depth
  localparam int VDN_IRQ_W        = 9;                    // External irq vector width
  localparam int VDN_IRQ_FRAME    = 0;                    // Vector bit for frame done

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  // One pixel with its markers
  typedef struct packed {
    logic                 sof;
    logic                 eol;
    logic [VDN_PIX_W-1:0] data;
  } vdn_pix_t;

  // A pipeline slot: pixel plus occupancy
  typedef struct packed {
    logic     valid;
    vdn_pix_t pix;
  } vdn_beat_t;

  // Input-side acceptance state, Gray along run -> line flush -> frame flush
  typedef enum logic [1:0] {
    VDN_RUN         = 2'b00,
    VDN_LINE_FLUSH  = 2'b01,
    VDN_FRAME_FLUSH = 2'b11
  } vdn_state_t;

endpackage

// *** src/vdn_fifo.sv ***
//------------------------------------------------------------------------------
// Purpose : Synchronous FIFO with valid/ready on both sides
// Assumes : Enable gates every update; reset overrides the enable
// Notes   : Output word is read straight from the array while not empty
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module vdn_fifo
  import vdn_pkg::*;
#(
  parameter int W     = 26,
  parameter int DEPTH = VDN_FIFO_DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             en,
  input  wire logic             in_valid,
  input  wire logic [W-1:0]     in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [W-1:0]     out_data,
  input  wire logic             out_ready,
  output logic      [CNT_W-1:0] count
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];   // Storage
  logic [AW-1:0] wr_ptr;        // Next write slot
  logic [AW-1:0] rd_ptr;        // Oldest word
  logic          push;          // Word enters
  logic          pop;           // Word leaves

  assign in_ready  = (count != CNT_W'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = en && in_valid && in_ready;
  assign pop       = en && out_valid && out_ready;

  //----------------------------------------------------------------------------
  // Pointers and fill level
  //----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // Array write, no reset needed
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // vdn_fifo

// *** src/vdn_line_buf.sv ***
//------------------------------------------------------------------------------
// Purpose : One-line delay that swaps a new pixel for the one stored a line ago
// Assumes : Caller steps it with adv and shift
// Notes   : Occupancy bits are reset, pixel storage is not
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module vdn_line_buf
  import vdn_pkg::*;
#(
  parameter int COLS = VDN_COLS
) (
  input  wire logic      mclk,
  input  wire logic      resetn,
  input  wire logic      adv,
  input  wire logic      shift,
  input  wire logic      in_valid,
  input  wire vdn_pix_t  in_pix,
  output vdn_beat_t      out_beat
);

  localparam int PW = $clog2(COLS);

  vdn_pix_t        mem [COLS];  // Stored line
  logic [COLS-1:0] vld;         // Slot holds a real pixel
  logic [PW-1:0]   ptr;         // Current column slot

  //----------------------------------------------------------------------------
  // Swap and readout
  //----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ptr      <= '0;
      vld      <= '0;
      out_beat <= '0;
    end else if (adv) begin
      if (shift) begin
        // Pixel from one line earlier leaves as the new one enters
        out_beat <= '{valid: vld[ptr], pix: mem[ptr]};
        vld[ptr] <= in_valid;
        ptr      <= (ptr == PW'(COLS - 1)) ? '0 : ptr + 1'b1;
      end else begin
        out_beat <= '0;
      end
    end
  end

  // Storage write
  always_ff @(posedge mclk) begin
    if (adv && shift) begin
      mem[ptr] <= in_pix;
    end
  end

endmodule // vdn_line_buf

// *** src/vdn_stream_flow.sv ***
//------------------------------------------------------------------------------
// Purpose : Streaming shell of the denoise filter: input buffer, line delay,
//           flush pipeline and output register with ready/valid throttling
// Assumes : All stream inputs synchronous to mclk; fixed frame geometry
// Notes   : Filter arithmetic is outside this shell; data passes unchanged
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module vdn_stream_flow
  import vdn_pkg::*;
#(
  parameter int ACTIVE_COLS = VDN_COLS,
  parameter int ACTIVE_ROWS = VDN_ROWS,
  parameter bit HAS_CTRL    = 1'b1,
  parameter bit HAS_EXT_IRQ = 1'b1
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  input  wire logic [VDN_PIX_W-1:0] s_axis_video_tdata,
  input  wire logic                 s_axis_video_tvalid,
  output logic                      s_axis_video_tready,
  input  wire logic                 s_axis_video_tuser,
  input  wire logic                 s_axis_video_tlast,
  output logic      [VDN_PIX_W-1:0] m_axis_video_tdata,
  output logic                      m_axis_video_tvalid,
  input  wire logic                 m_axis_video_tready,
  output logic                      m_axis_video_tuser,
  output logic                      m_axis_video_tlast,
  output logic                      irq,
  output logic      [VDN_IRQ_W-1:0] external_irq_vector
);

  //----------------------------------------------------------------------------
  // Local sizes
  //----------------------------------------------------------------------------
  localparam int CW    = $clog2(ACTIVE_COLS + VDN_FLUSH_CYCLES); // Flush counter
  localparam int RW    = $clog2(ACTIVE_ROWS + 1);                // Row counter
  localparam int FCW   = $clog2(VDN_FIFO_DEPTH + 1);             // FIFO fill level
  localparam int PIX_B = $bits(vdn_pix_t);

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  vdn_state_t     state;          // Input acceptance state
  vdn_state_t     next_state;     // Its next value
  logic [CW-1:0]  flush_cnt;      // Stall cycles left in this flush
  logic [CW-1:0]  next_flush_cnt; // Its next value
  logic [RW-1:0]  row_in;         // Lines accepted this frame
  logic [RW-1:0]  row_out;        // Lines popped into the line delay
  logic [CW-1:0]  drain_cnt;      // Bubble shifts left in frame drain
  logic           draining;       // Line delay is emptying at frame end
  logic           accept;         // Input beat transferred
  logic           accept_eol;     // Transferred beat ends a line
  logic           frame_end_in;   // Accepted line is the frame's last
  logic           next_ready;     // Next value of input ready
  vdn_pix_t       in_pix;         // Incoming pixel bundle
  logic           fifo_push_ok;   // FIFO write side ready
  logic           fifo_valid;     // FIFO holds a pixel
  logic [PIX_B-1:0] fifo_word;    // Oldest buffered pixel
  vdn_pix_t       fifo_pix;       // Same, as a struct
  logic [FCW-1:0] fifo_count;     // FIFO fill level
  logic           adv;            // Pipeline steps this cycle
  logic           pop;            // Pixel leaves the FIFO
  logic           shift;          // Line delay swaps a slot
  logic           frame_end_out;  // Popped pixel ends the frame
  logic           drain_done;     // Last bubble shift of the drain
  vdn_beat_t      pipe [VDN_PIPE_STAGES]; // Flush pipeline slots

  //----------------------------------------------------------------------------
  // Input side decode
  //----------------------------------------------------------------------------
  assign accept       = clk_en && s_axis_video_tvalid && s_axis_video_tready;
  assign accept_eol   = accept && s_axis_video_tlast;
  assign frame_end_in = (row_in == RW'(ACTIVE_ROWS - 1));
  assign in_pix       = '{sof: s_axis_video_tuser, eol: s_axis_video_tlast,
                          data: s_axis_video_tdata};

  //----------------------------------------------------------------------------
  // Acceptance state: run, line flush, frame flush
  //----------------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_flush_cnt = flush_cnt;
    case (state)
      VDN_RUN: begin
        if (accept_eol) begin
          // Stall starts on the cycle after the end-of-line beat
          next_state     = VDN_LINE_FLUSH;
          next_flush_cnt = CW'(VDN_FLUSH_CYCLES - 1);
        end
      end
      VDN_LINE_FLUSH: begin
        if (flush_cnt != '0) begin
          next_flush_cnt = flush_cnt - 1'b1;
        end else if (row_in == '0) begin
          // Frame just ended: hold input off for one line
          next_state     = VDN_FRAME_FLUSH;
          next_flush_cnt = CW'(ACTIVE_COLS - 1);
        end else begin
          next_state = VDN_RUN;
        end
      end
      VDN_FRAME_FLUSH: begin
        if (flush_cnt != '0) begin
          next_flush_cnt = flush_cnt - 1'b1;
        end else begin
          next_state = VDN_RUN;
        end
      end
      default: begin
        next_state     = VDN_RUN;
        next_flush_cnt = '0;
      end
    endcase
  end

  // Ready only in run and with room for two more beats after this one
  assign next_ready = (next_state == VDN_RUN) &&
                      ((fifo_count + FCW'(accept)) <= FCW'(VDN_FIFO_DEPTH - 2));

  // State, counters and registered input ready
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state               <= VDN_RUN;
      flush_cnt           <= '0;
      row_in              <= '0;
      s_axis_video_tready <= 1'b0;
    end else if (clk_en) begin
      state               <= next_state;
      flush_cnt           <= next_flush_cnt;
      s_axis_video_tready <= next_ready;
      if (accept_eol) begin
        row_in <= frame_end_in ? '0 : row_in + 1'b1;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Input buffer
  //----------------------------------------------------------------------------
  vdn_fifo #(
    .W     (PIX_B),
    .DEPTH (VDN_FIFO_DEPTH),
    .CNT_W (FCW)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .en        (clk_en),
    .in_valid  (accept),
    .in_data   (in_pix),
    .in_ready  (fifo_push_ok),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (pop),
    .count     (fifo_count)
  );

  assign fifo_pix = vdn_pix_t'(fifo_word);

  //----------------------------------------------------------------------------
  // Datapath stepping
  //----------------------------------------------------------------------------
  // Whole pipeline stalls only when enable is low or the output word is stuck
  assign adv           = clk_en && (!m_axis_video_tvalid || m_axis_video_tready);
  assign pop           = adv && fifo_valid && !draining;
  assign shift         = pop || (adv && draining);
  assign frame_end_out = pop && fifo_pix.eol && (row_out == RW'(ACTIVE_ROWS - 1));
  assign drain_done    = adv && draining && (drain_cnt == '0);

  // Row tracking on the pop side and frame drain of the line delay
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      row_out   <= '0;
      draining  <= 1'b0;
      drain_cnt <= '0;
    end else begin
      if (pop && fifo_pix.eol) begin
        row_out <= frame_end_out ? '0 : row_out + 1'b1;
      end
      if (frame_end_out) begin
        // Push a full line of bubbles to release the last line
        draining  <= 1'b1;
        drain_cnt <= CW'(ACTIVE_COLS - 1);
      end else if (drain_done) begin
        draining <= 1'b0;
      end else if (adv && draining) begin
        drain_cnt <= drain_cnt - 1'b1;
      end
    end
  end

  //----------------------------------------------------------------------------
  // One-line delay, first pipeline slot
  //----------------------------------------------------------------------------
  vdn_line_buf #(
    .COLS (ACTIVE_COLS)
  ) u_line (
    .mclk     (mclk),
    .resetn   (resetn),
    .adv      (adv),
    .shift    (shift),
    .in_valid (pop),
    .in_pix   (fifo_pix),
    .out_beat (pipe[0])
  );

  //----------------------------------------------------------------------------
  // Flush pipeline slots behind the line delay
  //----------------------------------------------------------------------------
  for (genvar i = 1; i < VDN_PIPE_STAGES; i++) begin : g_pipe
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        pipe[i] <= '0;
      end else if (adv) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  //----------------------------------------------------------------------------
  // Output register
  //----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      m_axis_video_tvalid <= 1'b0;
      m_axis_video_tdata  <= '0;
      m_axis_video_tuser  <= 1'b0;
      m_axis_video_tlast  <= 1'b0;
    end else if (adv) begin
      // Markers ride with their pixel, so one out per one in
      m_axis_video_tvalid <= pipe[VDN_PIPE_STAGES-1].valid;
      m_axis_video_tdata  <= pipe[VDN_PIPE_STAGES-1].pix.data;
      m_axis_video_tuser  <= pipe[VDN_PIPE_STAGES-1].pix.sof;
      m_axis_video_tlast  <= pipe[VDN_PIPE_STAGES-1].pix.eol;
    end
  end

  //----------------------------------------------------------------------------
  // Interrupt outputs, frame-drained pulse when configured
  //----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq                 <= 1'b0;
      external_irq_vector <= '0;
    end else if (clk_en) begin
      irq                                <= HAS_CTRL && drain_done;
      external_irq_vector[VDN_IRQ_FRAME] <= HAS_EXT_IRQ && drain_done;
    end
  end

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  logic [31:0] in_total;   // Beats accepted
  logic [31:0] out_total;  // Beats delivered
  logic [CW-1:0] low_run;  // Ready-low cycles since last line end
  logic        eol_seen;   // A line end opened the current stall

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      in_total  <= '0;
      out_total <= '0;
      low_run   <= '0;
      eol_seen  <= 1'b0;
    end else if (clk_en) begin
      in_total  <= in_total + 32'(accept);
      out_total <= out_total + 32'(m_axis_video_tvalid && m_axis_video_tready);
      if (accept_eol) begin
        eol_seen <= 1'b1;
        low_run  <= '0;
      end else if (!s_axis_video_tready && low_run != '1) begin
        low_run <= low_run + 1'b1;
      end else if (s_axis_video_tready) begin
        eol_seen <= 1'b0;
      end
    end
  end

  sequence s_eol_taken;
    accept_eol;
  endsequence

  sequence s_ready_held_low;
    (!s_axis_video_tready)[*8];
  endsequence

  a_eol_stall_start: assert property (@(posedge mclk) disable iff (!resetn)
    s_eol_taken |=> !s_axis_video_tready)
    else $error("input ready not dropped after end of line");

  a_eol_stall_hold: assert property (@(posedge mclk) disable iff (!resetn)
    s_eol_taken |=> s_ready_held_low)
    else $error("input ready rose early in line flush");

  a_eol_stall_len: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en && eol_seen && !s_axis_video_tready && next_ready |-> low_run >= CW'(VDN_FLUSH_CYCLES - 1))
    else $error("line flush stall shorter than required");

  a_frame_flush_go: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en && state == VDN_LINE_FLUSH && flush_cnt == '0 && row_in == '0
    |=> state == VDN_FRAME_FLUSH && flush_cnt == CW'(ACTIVE_COLS - 1))
    else $error("frame flush did not start for a full line");

  a_full_stops_in: assert property (@(posedge mclk) disable iff (!resetn)
    clk_en && (fifo_count + FCW'(accept)) > FCW'(VDN_FIFO_DEPTH - 2) |=> !s_axis_video_tready)
    else $error("input ready high with buffer near full");

  a_no_overflow: assert property (@(posedge mclk) disable iff (!resetn)
    accept |-> fifo_push_ok)
    else $error("input beat taken with buffer full");

  a_freeze_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !clk_en |=> $stable(m_axis_video_tvalid) && $stable(m_axis_video_tdata) &&
                $stable(s_axis_video_tready) && $stable(state))
    else $error("outputs moved while enable low");

  a_out_stall_hold: assert property (@(posedge mclk) disable iff (!resetn)
    m_axis_video_tvalid && !m_axis_video_tready |=> m_axis_video_tvalid &&
                                                    $stable(m_axis_video_tdata))
    else $error("output beat dropped before transfer");

  a_beat_balance: assert property (@(posedge mclk) disable iff (!resetn)
    out_total <= in_total)
    else $error("more pixels out than accepted");

  a_reset_clears: assert property (@(posedge mclk)
    !resetn |=> !s_axis_video_tready && !m_axis_video_tvalid && !irq)
    else $error("reset did not clear outputs");

endmodule // vdn_stream_flow

// *** verif/vdn_partner.sv ***
// Purpose : Upstream video source and downstream sink for the stream shell
// Assumes : Both sides drive on the falling edge of mclk
// Notes   : Source stops after nframes frames; idle data shows inverted pixel
`timescale 1ns/1ps
module vdn_partner
  import vdn_pkg::*;
#(
  parameter int COLS = 32,
  parameter int ROWS = 4
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic [6:0] gap,
  input  wire logic [6:0] busy,
  input  wire logic [3:0] nframes,
  input  wire logic       s_ready,
  output vdn_pix_t        s_pix,
  output logic            s_valid,
  output logic            m_ready,
  output logic [3:0]      fr_cnt
);
  int   col;
  int   row;
  logic took;
  initial begin
    s_valid = 1'b0;
    s_pix = '0;
    m_ready = 1'b0;
    fr_cnt = 4'h0;
  end
  // Beat moved at this edge
  always @(posedge mclk) took <= s_valid & s_ready & clk_en & resetn;
  // Source holds each beat until taken; sink stalls at random
  always @(negedge mclk) begin
    m_ready = ($urandom % 100) >= busy;
    if (!resetn) begin
      col = 0;
      row = 0;
      fr_cnt = 4'h0;
      s_valid = 1'b0;
    end else if (took || !s_valid) begin
      if (took) begin
        col = (col + 1) % COLS;
        if (col == 0) row = (row + 1) % ROWS;
        if (col == 0 && row == 0) fr_cnt = fr_cnt + 4'h1;
      end
      s_valid = (fr_cnt < nframes) && (($urandom % 100) >= gap);
      s_pix.data = s_valid ? 24'($urandom) : ~s_pix.data;
      s_pix.sof = s_valid && col == 0 && row == 0;
      s_pix.eol = s_valid && col == COLS - 1;
    end
  end
endmodule // vdn_partner

// *** verif/tb_vdn_stream_flow.sv ***
// Purpose : Self-checking bench for the stream shell
// Assumes : Small frame geometry; inputs change on the falling edge
// Notes   : Accepted beats are queued and matched against output beats
`timescale 1ns/1ps
module tb_vdn_stream_flow
  import vdn_pkg::*;
  ;
  localparam int COLS = 32;
  localparam int ROWS = 4;
  logic                 mclk;
  logic                 resetn;
  logic                 clk_en;
  logic                 stall;
  logic [6:0]           gap;
  logic [6:0]           busy;
  logic [3:0]           nframes;
  logic [3:0]           fr_cnt;
  vdn_pix_t             s_pix;
  logic                 s_valid;
  logic                 s_ready;
  logic [VDN_PIX_W-1:0] m_tdata;
  logic                 m_valid;
  logic                 m_ready;
  logic                 m_tuser;
  logic                 m_tlast;
  logic                 irq;
  logic [VDN_IRQ_W-1:0] irq_vec;
  vdn_pix_t             q[$];     // Accepted beats awaiting output
  vdn_pix_t             got;
  logic [27:0]          prev;     // Outputs seen at a frozen edge
  logic                 prev_frz = 1'b0;
  int                   fl = -1;  // Expected ready-low cycles left
  int                   lines = 0;
  int                   irqs = 0;  // Frame-drained pulses seen
  int                   errors = 0;
  int                   check_count = 0;

  vdn_stream_flow #(.ACTIVE_COLS(COLS), .ACTIVE_ROWS(ROWS)) u_vdn_stream_flow (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .s_axis_video_tdata(s_pix.data),
    .s_axis_video_tvalid(s_valid), .s_axis_video_tready(s_ready),
    .s_axis_video_tuser(s_pix.sof), .s_axis_video_tlast(s_pix.eol),
    .m_axis_video_tdata(m_tdata), .m_axis_video_tvalid(m_valid),
    .m_axis_video_tready(m_ready), .m_axis_video_tuser(m_tuser),
    .m_axis_video_tlast(m_tlast), .irq(irq), .external_irq_vector(irq_vec));
  vdn_partner #(.COLS(COLS), .ROWS(ROWS)) u_vdn_partner (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .gap(gap), .busy(busy),
    .nframes(nframes), .s_ready(s_ready), .s_pix(s_pix), .s_valid(s_valid),
    .m_ready(m_ready), .fr_cnt(fr_cnt));

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_pix(input vdn_pix_t g, input vdn_pix_t e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t pixel %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Send frames, wait for the drain and 100 more cycles, then check the output is idle once and one irq per frame
  task automatic run(input int n);
    int i;
    int f0;
    int k;
    f0 = fr_cnt;
    k = irqs;
    nframes = 4'(n);
    for (i = 0; i < 20000 && !(fr_cnt == nframes && q.size() == 0); i++) @(negedge mclk);
    repeat (100) @(negedge mclk);
    chk_val(fr_cnt, nframes);
    chk_val(q.size(), 0);
    chk_val(m_valid, 0);
    chk_val(irqs - k, n - f0);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Random enable drops
  always @(negedge mclk) if (stall) clk_en <= ($urandom % 5) != 0;
  // Monitor: freeze, flush stalls, and in-order output matching
  always @(posedge mclk) begin
    got = {m_tuser, m_tlast, m_tdata};
    if (prev_frz) chk_val(prev, {s_ready, m_valid, got});
    prev_frz = resetn && !clk_en;
    prev = {s_ready, m_valid, got};
    if (!resetn) begin
      q.delete();
      fl = -1;
      lines = 0;
    end else if (clk_en) begin
      if (fl > 0) chk_val(s_ready, 0);
      else if (fl == 0 && busy == 0) chk_val(s_ready, 1);
      fl = fl - 1;
      if (irq) irqs++;
      chk_val(irq_vec, 32'(irq));
      if (s_valid && s_ready) begin
        q.push_back(s_pix);
        if (s_pix.eol) begin
          lines = lines + 1;
          fl = VDN_FLUSH_CYCLES + ((lines % ROWS == 0) ? COLS : 0);
        end
      end
      if (m_valid && m_ready) begin
        if (q.size() == 0) chk_val(1, 0);
        else chk_pix(got, q.pop_front());
      end
    end
  end
  // Watchdog
  initial begin
    #(60000 * 5);
    errors++;
    end_of_test;
  end
  initial begin
    void'($urandom(44944));
    {resetn, clk_en, stall, gap, busy, nframes} = '0;
    clk_en = 1'b1;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    run(1);
    gap = 7'd30;
    busy = 7'd40;
    stall = 1'b1;
    run(3);
    stall = 1'b0;
    gap = 7'd0;
    busy = 7'd0;
    @(negedge mclk);
    clk_en = 1'b1;
    nframes = 4'h4;
    repeat (100) @(negedge mclk);
    clk_en = 1'b0;
    resetn = 1'b0;
    @(negedge mclk);
    chk_val({s_ready, m_valid}, 0);
    @(negedge mclk);
    resetn = 1'b1;
    clk_en = 1'b1;
    run(1);
    end_of_test;
  end
endmodule // tb_vdn_stream_flow
